// ===== vlan_table_regs.svh
`ifndef VLAN_TABLE_REGS_SVH
`define VLAN_TABLE_REGS_SVH
// Register indices; byte address is four times the index
`define IDX_AGING_CFG   14'h1809
`define IDX_CMD         14'h180b
`define IDX_WR_DATA     14'h180c
`define IDX_CMD_STS     14'h180d
`define IDX_RD_DATA     14'h180e
`define IDX_ADMIT_NM    14'h1810
`define IDX_EGR_TYPE    14'h1811
// Field positions
`define AGING_TEST_BIT  0
`define STS_PENDING_BIT 0
`define CMD_DIR_BIT     5
`define CMD_SEL_BIT     4
`define CMD_IDX_MSB     3
`define CMD_W           6
`define DATA_W          18
`define PORT_CFG_W      15
`define VID_MSB         11
`define PRI_LSB         12
`define PRI_MSB         14
`define MEMBER_BASE     13
`define UNTAG_BASE      12
// Reset values
`define CMD_RST         6'h00
`define DATA_RST        18'h00000
`define PORT_MASK_RST   3'h0
// Timing
`define CLK_KHZ         50000
`define AGE_NORMAL_MS   300000
`define AGE_TEST_MS     50
`endif

// ===== vlan_table_pkg.sv
package vlan_table_pkg;
    typedef logic [11:0] vid_t;
    typedef logic [2:0]  pri_t;
    typedef logic [2:0]  port_mask_t;
    typedef logic [17:0] entry_t;
    typedef logic [14:0] port_cfg_t;
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ACCESS  = 2'b01,
        ST_CAPTURE = 2'b10
    } access_st_t;
endpackage

// ===== table_if.sv
interface table_if;
    import vlan_table_pkg::*;
    logic      wr_stb;
    logic      rd_stb;
    logic      sel_port;
    logic [3:0] index;
    entry_t    wdata;
    entry_t    rdata;
    entry_t    entry [16];
    port_cfg_t pcfg [3];
    modport engine (output wr_stb, rd_stb, sel_port, index, wdata,
                    input rdata, entry, pcfg);
    modport store  (input wr_stb, rd_stb, sel_port, index, wdata,
                    output rdata, entry, pcfg);
endinterface

// ===== vlan_table_store.sv
`include "vlan_table_regs.svh"
module vlan_table_store #(
    parameter int NUM_VLANS = 16,
    parameter int NUM_PORTS = 3
) (
    input  wire logic clk,
    input  wire logic srst,
    table_if.store    t
);
    import vlan_table_pkg::*;

    entry_t    entry_ff [NUM_VLANS];
    port_cfg_t pcfg_ff [NUM_PORTS];
    entry_t    rdata_ff;
    entry_t    rd_mux;

    genvar g;
    generate
        for (g = 0; g < NUM_VLANS; g++) begin : g_vlan
            always_ff @(posedge clk) begin
                if (srst) begin
                    entry_ff[g] <= `DATA_RST;
                end else if (t.wr_stb && !t.sel_port && t.index == 4'(g)) begin
                    entry_ff[g] <= t.wdata;
                end
            end
            assign t.entry[g] = entry_ff[g];
        end
        for (g = 0; g < NUM_PORTS; g++) begin : g_port
            always_ff @(posedge clk) begin
                if (srst) begin
                    pcfg_ff[g] <= `PORT_CFG_W'(0);
                end else if (t.wr_stb && t.sel_port && t.index == 4'(g)) begin
                    // Reserved data bits are not kept
                    pcfg_ff[g] <= t.wdata[`PORT_CFG_W-1:0];
                end
            end
            assign t.pcfg[g] = pcfg_ff[g];
        end
    endgenerate

    // Port indices past the last port read as zero
    assign rd_mux = !t.sel_port ? entry_ff[t.index] :
                    (t.index < 4'(NUM_PORTS)) ? {3'h0, pcfg_ff[t.index[1:0]]} : `DATA_RST;

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_ff <= `DATA_RST;
        end else if (t.rd_stb) begin
            rdata_ff <= rd_mux;
        end
    end
    assign t.rdata = rdata_ff;
endmodule

// ===== vlan_table_access.sv
// What this block does
// - Aging test bit shortens aging period from five minutes to 50 ms.
// - Every command register write with byte lane 0 enabled launches exactly one table access.
// - Command bit 5 picks direction: one reads, zero writes.
// - Command bit 4 picks port default table, else VLAN table.
// - Command bits 3:0 give entry index, VLAN 0-15 or port 0-2.
// - Port entry: bits 11:0 default VID, bits 14:12 default priority.
// - Untagged or null-VID frames take their port's default VID and priority.
// - Entry bit 17 makes port 2 a member: admitted, in egress domain.
// - Non-member port 2 filtered unless admit-non-member set; not in domain.
// - Entry bit 16 strips tags of port 2 frames on hybrid egress ports.
// - Entry bit 15 is port 1 membership, behaving like port 2.
// - Bit 14 port 1 untag, bit 13 host member, bit 12 host untag.
// - Entry bits 11:0 are the VID matched against frames.
`include "vlan_table_regs.svh"
module vlan_table_access #(
    parameter logic [39:0] AGE_NORMAL_CYC = 40'(`AGE_NORMAL_MS) * 40'(`CLK_KHZ),
    parameter logic [39:0] AGE_TEST_CYC   = 40'(`AGE_TEST_MS) * 40'(`CLK_KHZ)
) (
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [15:0]               wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output      logic [31:0]               wb_dat_o,
    output      logic                      wb_ack_o,
    output      logic                      aging_tick,
    input  wire logic                      lk_valid,
    input  wire logic [1:0]                lk_port,
    input  wire logic                      lk_tagged,
    input  wire vlan_table_pkg::vid_t      lk_vid,
    input  wire vlan_table_pkg::pri_t      lk_pri,
    output      logic                      res_valid,
    output      logic                      res_hit,
    output      logic                      res_admit,
    output      vlan_table_pkg::vid_t      res_vid,
    output      vlan_table_pkg::pri_t      res_pri,
    output      vlan_table_pkg::port_mask_t res_egress_mask,
    output      vlan_table_pkg::port_mask_t res_strip_mask
);
    import vlan_table_pkg::*;

    table_if t ();

    vlan_table_store u_store (
        .clk  (clk),
        .srst (srst),
        .t    (t)
    );

    // Bus decode
    logic                  ack_ff;
    logic [31:0]           dat_o_ff;
    logic                  aging_ff;
    logic [`CMD_W-1:0]     cmd_ff;
    entry_t                wr_data_ff;
    entry_t                rd_data_ff;
    port_mask_t            admit_ff;
    port_mask_t            egr_type_ff;
    logic                  pending_ff;
    access_st_t            state_ff;
    access_st_t            nxt_state;
    logic [39:0]           age_cnt_ff;
    logic                  tick_ff;

    wire logic [13:0] idx       = wb_adr_i[15:2];
    wire logic        req       = wb_cyc_i && wb_stb_i;
    wire logic        is_aging  = idx == `IDX_AGING_CFG;
    wire logic        is_cmd    = idx == `IDX_CMD;
    wire logic        is_wdata  = idx == `IDX_WR_DATA;
    wire logic        is_sts    = idx == `IDX_CMD_STS;
    wire logic        is_rdata  = idx == `IDX_RD_DATA;
    wire logic        is_admit  = idx == `IDX_ADMIT_NM;
    wire logic        is_egr    = idx == `IDX_EGR_TYPE;
    // A command write is held off, not dropped, while an access runs
    wire logic        stall     = wb_we_i && is_cmd && state_ff != ST_IDLE;
    wire logic        start     = req && !ack_ff && !stall;
    wire logic        wr_fire   = req && wb_we_i && ack_ff;
    wire logic [31:0] wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire logic        lane0     = wb_sel_i[0];
    wire logic        launch    = wr_fire && is_cmd && lane0;
    wire entry_t      nxt_wr_data = (wr_data_ff & ~wmask[`DATA_W-1:0]) |
                                    (wb_dat_i[`DATA_W-1:0] & wmask[`DATA_W-1:0]);

    // Unmapped indices read as zero and ignore writes
    wire logic [31:0] rd_mux =
        is_aging ? {31'h0, aging_ff} :
        is_cmd   ? {26'h0, cmd_ff} :
        is_wdata ? {14'h0, wr_data_ff} :
        is_sts   ? {31'h0, pending_ff} :
        is_rdata ? {14'h0, rd_data_ff} :
        is_admit ? {29'h0, admit_ff} :
        is_egr   ? {29'h0, egr_type_ff} : 32'h0;

    always_ff @(posedge clk) begin
        if (srst) begin
            ack_ff   <= 1'b0;
            dat_o_ff <= 32'h0;
        end else begin
            ack_ff <= start;
            if (start && !wb_we_i) begin
                dat_o_ff <= rd_mux;
            end
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_o_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            aging_ff    <= 1'b0;
            cmd_ff      <= `CMD_RST;
            wr_data_ff  <= `DATA_RST;
            admit_ff    <= `PORT_MASK_RST;
            egr_type_ff <= `PORT_MASK_RST;
        end else if (wr_fire && lane0) begin
            if (is_aging) aging_ff    <= wb_dat_i[`AGING_TEST_BIT];
            if (is_cmd)   cmd_ff      <= wb_dat_i[`CMD_W-1:0];
            if (is_admit) admit_ff    <= wb_dat_i[2:0];
            if (is_egr)   egr_type_ff <= wb_dat_i[2:0];
            if (is_wdata) wr_data_ff  <= nxt_wr_data;
        end else if (wr_fire && is_wdata) begin
            wr_data_ff <= nxt_wr_data;
        end
    end

    // Access engine
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:    if (launch) nxt_state = ST_ACCESS;
            ST_ACCESS:  nxt_state = ST_CAPTURE;
            ST_CAPTURE: nxt_state = ST_IDLE;
            default:    nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff   <= ST_IDLE;
            pending_ff <= 1'b0;
            rd_data_ff <= `DATA_RST;
        end else begin
            state_ff <= nxt_state;
            if (launch) begin
                pending_ff <= 1'b1;
            end else if (state_ff == ST_CAPTURE) begin
                pending_ff <= 1'b0;
            end
            if (state_ff == ST_CAPTURE && cmd_ff[`CMD_DIR_BIT]) begin
                rd_data_ff <= t.rdata;
            end
        end
    end

    assign t.rd_stb   = state_ff == ST_ACCESS && cmd_ff[`CMD_DIR_BIT];
    assign t.wr_stb   = state_ff == ST_ACCESS && !cmd_ff[`CMD_DIR_BIT];
    assign t.sel_port = cmd_ff[`CMD_SEL_BIT];
    assign t.index    = cmd_ff[`CMD_IDX_MSB:0];
    assign t.wdata    = wr_data_ff;

    wire logic [39:0] age_limit = aging_ff ? AGE_TEST_CYC : AGE_NORMAL_CYC;
    wire logic        age_wrap  = age_cnt_ff >= age_limit - 40'h1;

    always_ff @(posedge clk) begin
        if (srst) begin
            age_cnt_ff <= 40'h0;
            tick_ff    <= 1'b0;
        end else begin
            age_cnt_ff <= age_wrap ? 40'h0 : age_cnt_ff + 40'h1;
            tick_ff    <= age_wrap;
        end
    end
    assign aging_tick = tick_ff;

    // Lookup path
    wire logic      port_ok  = lk_port != 2'd3;
    wire port_cfg_t def_cfg  = port_ok ? t.pcfg[lk_port] : `PORT_CFG_W'(0);
    wire logic      use_def  = !lk_tagged || lk_vid == 12'h000;
    wire vid_t      eff_vid  = use_def ? def_cfg[`VID_MSB:0] : lk_vid;
    wire pri_t      eff_pri  = use_def ? def_cfg[`PRI_MSB:`PRI_LSB] : lk_pri;

    logic [15:0] match;
    entry_t      acc [17];
    assign acc[0] = `DATA_RST;
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_match
            assign match[g]  = t.entry[g][`VID_MSB:0] == eff_vid && eff_vid != 12'h000;
            assign acc[g+1] = acc[g] | ({`DATA_W{match[g]}} & t.entry[g]);
        end
    endgenerate
    wire entry_t hit_ent = acc[16];
    wire logic   hit     = |match;

    wire port_mask_t members = {hit_ent[`MEMBER_BASE+4], hit_ent[`MEMBER_BASE+2],
                                hit_ent[`MEMBER_BASE]};
    wire port_mask_t untags  = {hit_ent[`UNTAG_BASE+4], hit_ent[`UNTAG_BASE+2],
                                hit_ent[`UNTAG_BASE]};
    wire logic member_in = port_ok && members[lk_port];
    wire logic admit_nm  = port_ok && admit_ff[lk_port];
    wire logic untag_in  = port_ok && untags[lk_port];
    wire logic admit     = hit && (member_in || admit_nm);

    always_ff @(posedge clk) begin
        if (srst) begin
            res_valid       <= 1'b0;
            res_hit         <= 1'b0;
            res_admit       <= 1'b0;
            res_vid         <= 12'h000;
            res_pri         <= 3'h0;
            res_egress_mask <= `PORT_MASK_RST;
            res_strip_mask  <= `PORT_MASK_RST;
        end else begin
            res_valid <= lk_valid;
            if (lk_valid) begin
                res_hit         <= hit;
                res_admit       <= admit;
                res_vid         <= eff_vid;
                res_pri         <= eff_pri;
                res_egress_mask <= members & {3{hit}};
                res_strip_mask  <= egr_type_ff & {3{hit && untag_in}};
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_access;
        state_ff == ST_ACCESS ##1 state_ff == ST_CAPTURE;
    endsequence

    property p_launch_pending;
        launch |=> pending_ff ##0 s_access ##1 !pending_ff && state_ff == ST_IDLE;
    endproperty
    a_launch_pending: assert property (p_launch_pending)
        else $error("pending not raised then cleared after three cycles");

    property p_busy_holds;
        req && wb_we_i && is_cmd && pending_ff |-> !wb_ack_o;
    endproperty
    a_busy_holds: assert property (p_busy_holds)
        else $error("command write acked while access busy");

    property p_dir;
        launch |=> (t.rd_stb == $past(wb_dat_i[5])) && (t.wr_stb != $past(wb_dat_i[5]));
    endproperty
    a_dir: assert property (p_dir)
        else $error("access direction differs from command bit 5");

    property p_sel_idx;
        launch |=> t.sel_port == $past(wb_dat_i[4]) && t.index == $past(wb_dat_i[3:0]);
    endproperty
    a_sel_idx: assert property (p_sel_idx)
        else $error("table select or index differs from command");

    property p_port_write;
        t.wr_stb && t.sel_port && t.index == 4'h1 |=> t.pcfg[1] == $past(t.wdata[14:0]);
    endproperty
    a_port_write: assert property (p_port_write)
        else $error("port default entry not written");

    property p_age_test;
        aging_ff && $past(aging_ff) |-> age_cnt_ff < AGE_TEST_CYC;
    endproperty
    a_age_test: assert property (p_age_test)
        else $error("aging counter passed the test period");

    property p_default_vid;
        lk_valid && !lk_tagged && lk_port == 2'd1 |=> res_vid == $past(t.pcfg[1][11:0]);
    endproperty
    a_default_vid: assert property (p_default_vid)
        else $error("untagged frame did not take port default VID");

    property p_filter_p2;
        lk_valid && lk_port == 2'd2 && !admit_ff[2] && !hit_ent[17] |=> !res_admit;
    endproperty
    a_filter_p2: assert property (p_filter_p2)
        else $error("non-member frame on port 2 admitted");

    property p_member_p1;
        lk_valid && lk_port == 2'd1 && hit && hit_ent[15] |=> res_admit && res_egress_mask[1];
    endproperty
    a_member_p1: assert property (p_member_p1)
        else $error("port 1 member frame refused");

    property p_strip;
        lk_valid && lk_port == 2'd2 && hit && hit_ent[16] |=> res_strip_mask == $past(egr_type_ff);
    endproperty
    a_strip: assert property (p_strip)
        else $error("untag did not strip on hybrid ports");
endmodule

// ===== tb.sv
`include "vlan_table_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import vlan_table_pkg::*;
    localparam logic [39:0] NORM_CYC = 40'd200;
    localparam logic [39:0] TEST_CYC = 40'd20;
    localparam int          LIMIT    = 20000;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [15:0] wb_adr = 16'h0000;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        aging_tick;
    logic        lk_valid = 1'b0;
    logic [1:0]  lk_port = 2'h0;
    logic        lk_tagged = 1'b0;
    vid_t        lk_vid = 12'h000;
    pri_t        lk_pri = 3'h0;
    logic        res_valid;
    logic        res_hit;
    logic        res_admit;
    vid_t        res_vid;
    pri_t        res_pri;
    port_mask_t  res_egress_mask;
    port_mask_t  res_strip_mask;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cyc_cnt = 0;

    vlan_table_access #(.AGE_NORMAL_CYC(NORM_CYC), .AGE_TEST_CYC(TEST_CYC)) uut (
        .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .aging_tick(aging_tick), .lk_valid(lk_valid),
        .lk_port(lk_port), .lk_tagged(lk_tagged), .lk_vid(lk_vid), .lk_pri(lk_pri),
        .res_valid(res_valid), .res_hit(res_hit), .res_admit(res_admit),
        .res_vid(res_vid), .res_pri(res_pri), .res_egress_mask(res_egress_mask),
        .res_strip_mask(res_strip_mask));

    always #10 clk = ~clk;

    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard, well above the several hundred cycles the run needs
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == LIMIT) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end

    task automatic cmp_word(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_res(string what, logic [23:0] exp, logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_count(string what, int exp, int got);
        n_tests++;
        if (got != exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Request held until ack is sampled high, then one idle cycle
    task automatic wb_xfer(logic we, logic [13:0] idx, logic [31:0] d, output logic [31:0] q,
                           input logic [3:0] s = 4'hf);
        int n;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= {idx, 2'b00};
        wb_sel <= s;
        wb_dat <= d;
        n = 0;
        // Only the global hang guard ends this wait
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge clk);
        // Ack one cycle after request, up to three more while stalled
        cmp_count("ack_latency", 1, int'(n <= 5));
    endtask

    task automatic wr(logic [13:0] idx, logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, idx, d, q);
    endtask

    task automatic rd_chk(string what, logic [13:0] idx, logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, idx, 32'h00000000, q);
        cmp_word(what, exp, q);
    endtask

    task automatic wait_idle();
        logic [31:0] q;
        do begin
            wb_xfer(1'b0, `IDX_CMD_STS, 32'h00000000, q);
        end while (q[0] !== 1'b0);
        cmp_word("pending", 32'h00000000, q);
    endtask

    task automatic t_reset_and_map();
        logic [13:0] idx [9] = '{`IDX_AGING_CFG, `IDX_CMD, `IDX_WR_DATA, `IDX_CMD_STS,
            `IDX_RD_DATA, `IDX_ADMIT_NM, `IDX_EGR_TYPE, 14'h1812, 14'h0000};
        logic [31:0] q;
        wr(14'h1812, 32'hffffffff);
        foreach (idx[i]) rd_chk("reset_value", idx[i], 32'h00000000);
        wr(`IDX_AGING_CFG, 32'hffffffff);
        rd_chk("aging_cfg", `IDX_AGING_CFG, 32'h00000001);
        wr(`IDX_WR_DATA, 32'hffffffff);
        rd_chk("wr_data", `IDX_WR_DATA, 32'h0003ffff);
        // Lane 2 alone clears only bits 17:16
        wb_xfer(1'b1, `IDX_WR_DATA, 32'h00000000, q, 4'h4);
        rd_chk("wr_data_lane2", `IDX_WR_DATA, 32'h0000ffff);
        wr(`IDX_RD_DATA, 32'hffffffff);
        rd_chk("rd_data_ro", `IDX_RD_DATA, 32'h00000000);
    endtask

    task automatic measure(output int per);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (aging_tick !== 1'b1 && k < 1000);
        per = 0;
        do begin
            @(posedge clk);
            per++;
        end while (aging_tick !== 1'b1 && per < 1000);
    endtask

    task automatic t_aging();
        int per;
        measure(per);
        cmp_count("aging_test_period", int'(TEST_CYC), per);
        wr(`IDX_AGING_CFG, 32'h00000000);
        measure(per);
        cmp_count("aging_normal_period", int'(NORM_CYC), per);
    endtask

    task automatic tbl_write(logic sel, logic [3:0] idx, logic [31:0] d);
        wr(`IDX_WR_DATA, d);
        wr(`IDX_CMD, {26'h0, 1'b0, sel, idx});
        wait_idle();
    endtask

    task automatic tbl_read_chk(string what, logic sel, logic [3:0] idx, logic [31:0] exp);
        wr(`IDX_CMD, {26'h0, 1'b1, sel, idx});
        wait_idle();
        rd_chk(what, `IDX_RD_DATA, exp);
    endtask

    task automatic t_tables();
        tbl_write(1'b0, 4'h0, 32'h0003a123);
        tbl_read_chk("vlan_entry0", 1'b0, 4'h0, 32'h0003a123);
        // Second command issued while the first is still pending
        wr(`IDX_WR_DATA, 32'hfffca456);
        wr(`IDX_CMD, 32'h0000000f);
        wr(`IDX_CMD, 32'h0000002f);
        wait_idle();
        rd_chk("vlan_entry15", `IDX_RD_DATA, 32'h0000a456);
        rd_chk("command_reg", `IDX_CMD, 32'h0000002f);
        tbl_write(1'b1, 4'h2, 32'h0003fabc);
        tbl_write(1'b1, 4'h1, 32'h00003123);
        tbl_read_chk("port2_default", 1'b1, 4'h2, 32'h00007abc);
        tbl_read_chk("port0_default", 1'b1, 4'h0, 32'h00000000);
        tbl_read_chk("vlan_entry0_again", 1'b0, 4'h0, 32'h0003a123);
    endtask

    task automatic look(string what, logic [1:0] p, logic tg, vid_t v, pri_t pr,
                        logic [23:0] exp);
        lk_valid  <= 1'b1;
        lk_port   <= p;
        lk_tagged <= tg;
        lk_vid    <= v;
        lk_pri    <= pr;
        @(posedge clk);
        lk_valid <= 1'b0;
        @(posedge clk);
        cmp_res(what, exp, {res_valid, res_hit, res_admit, res_vid, res_pri,
                            res_egress_mask, res_strip_mask});
    endtask

    task automatic t_lookup();
        wr(`IDX_EGR_TYPE, 32'h00000003);
        // Fields: valid, hit, admit, vid, pri, egress, strip
        look("p2_member", 2'd2, 1'b1, 12'h123, 3'd5,
             {3'b111, 12'h123, 3'd5, 3'b111, 3'b011});
        look("p1_untagged", 2'd1, 1'b0, 12'h999, 3'd0,
             {3'b111, 12'h123, 3'd3, 3'b111, 3'b000});
        look("p0_null_vid", 2'd0, 1'b1, 12'h000, 3'd6,
             {3'b100, 12'h000, 3'd0, 3'b000, 3'b000});
        look("p2_nonmember", 2'd2, 1'b1, 12'h456, 3'd1,
             {3'b110, 12'h456, 3'd1, 3'b011, 3'b000});
        wr(`IDX_ADMIT_NM, 32'h00000004);
        look("p2_admit_nm", 2'd2, 1'b1, 12'h456, 3'd1,
             {3'b111, 12'h456, 3'd1, 3'b011, 3'b000});
    endtask

    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset_and_map();
        t_aging();
        t_tables();
        t_lookup();
        tally_and_finish();
    end
endmodule
